//--- logic/somi_defines.vh
`ifndef SOMI_DEFINES_VH
`define SOMI_DEFINES_VH

// Bus geometry
`define SOMI_ADDR_W 8
`define SOMI_DATA_W 32

// Register byte offsets
`define SOMI_OFF_MONITOR 8'h00
`define SOMI_OFF_WIDTH 8'h04
`define SOMI_OFF_CONFIG 8'h08
`define SOMI_OFF_STATUS 8'h0C
`define SOMI_OFF_CLEAR 8'h10
`define SOMI_OFF_ENABLE 8'h14
`define SOMI_OFF_OUTPUT 8'h18

// Register select positions
`define SOMI_SEL_MONITOR 0
`define SOMI_SEL_WIDTH 1
`define SOMI_SEL_CONFIG 2
`define SOMI_SEL_STATUS 3
`define SOMI_SEL_CLEAR 4
`define SOMI_SEL_ENABLE 5
`define SOMI_SEL_OUTPUT 6
`define SOMI_SEL_W 7

// Monitor bit positions
`define SOMI_MON_THERMAL_UNDER 0
`define SOMI_MON_THERMAL_OVER 1
`define SOMI_MON_TORQUE_OVER 2
`define SOMI_MON_TORQUE_UNDER 3
`define SOMI_MON_VELERR_OVER 4
`define SOMI_MON_VELERR_UNDER 5
`define SOMI_MON_VEL_OVER 6
`define SOMI_MON_VEL_UNDER 7
`define SOMI_MON_WARNING 8
`define SOMI_MON_ZONE_A 9
`define SOMI_MON_ZONE_B 10
`define SOMI_MON_ZONE_C 11
`define SOMI_MON_W 12
// Extra synchronised inputs after the monitor bits
`define SOMI_SYN_POS_ERR 12
`define SOMI_SYN_INDEX 13
`define SOMI_SYN_MSB 14
`define SOMI_SYN_W 15

// Status, clear and enable bit positions
`define SOMI_EVT_INPOS_RISE 0
`define SOMI_EVT_INPOS_FALL 1
`define SOMI_EVT_WARN_RISE 2
`define SOMI_EVT_W 3

// Field positions
`define SOMI_CFG_INDEX_FMT 0
`define SOMI_OUT_INPOS 0
`define SOMI_OUT_MODE_LATCH 1
`define SOMI_OUT_MODE_FOLLOW 2
`define SOMI_OUT_MODE_PULSE 3
`define SOMI_OUT_TIMING 4

// Reset values; width counts in 0.1 ms units, -1.0 ms
`define SOMI_RST_WIDTH 32'hFFFFFFF6
`define SOMI_RST_CONFIG 1'b0
`define SOMI_RST_ENABLE 3'h0

// Timing
`define SOMI_CLK_PERIOD_NS 25
`define SOMI_WIDTH_UNIT_NS 100000
`define SOMI_UNIT_CYCLES (`SOMI_WIDTH_UNIT_NS / `SOMI_CLK_PERIOD_NS)
`define SOMI_PRE_W 12
`define SOMI_WIDTH_MAX 17'd100000
`define SOMI_CNT_W 17

// Responses
`define SOMI_RESP_OKAY 2'b00
`define SOMI_RESP_DECERR 2'b11

`endif

//--- logic/somi_sync.v
`timescale 1ns/10ps
`default_nettype none
`include "somi_defines.vh"

module somi_sync (
  input wire aclk,
  input wire aresetn,
  input wire [`SOMI_SYN_W-1:0] async_in,
  output wire [`SOMI_SYN_W-1:0] sync_out
);

  reg [`SOMI_SYN_W-1:0] stage1;
  reg [`SOMI_SYN_W-1:0] stage2;

  // Two flip-flops per bit; only stage2 reads stage1
  genvar i;
  generate
    for (i = 0; i < `SOMI_SYN_W; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule
`default_nettype wire

//--- logic/somi_inpos.v
`timescale 1ns/10ps
`default_nettype none
`include "somi_defines.vh"

module somi_inpos (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] inpos_width_setting,
  input wire positioning_start,
  input wire positioning_done,
  input wire pos_err_ok,
  output reg in_position_out,
  output wire mode_latched,
  output wire mode_follow,
  output wire mode_pulse,
  output wire timing
);

  localparam integer PRE_LAST_I = `SOMI_UNIT_CYCLES - 1;
  localparam [`SOMI_PRE_W-1:0] PRE_LAST = PRE_LAST_I[`SOMI_PRE_W-1:0];

  reg [`SOMI_PRE_W-1:0] pre;
  reg [`SOMI_CNT_W-1:0] remaining;
  reg busy;
  reg pending;
  reg follow;
  wire [31:0] neg_width;
  wire [31:0] abs_width;
  wire [`SOMI_CNT_W-1:0] mag;
  wire tick;

  // Mode from the sign of the width setting
  assign mode_latched = inpos_width_setting[31];
  assign mode_follow = (inpos_width_setting == 32'h00000000);
  assign mode_pulse = !mode_latched && !mode_follow;
  assign timing = busy;

  // Magnitude in 0.1 ms units, clamped to the largest width
  assign neg_width = ~inpos_width_setting + 32'h00000001;
  assign abs_width = mode_latched ? neg_width : inpos_width_setting;
  assign mag = (abs_width > {15'h0000, `SOMI_WIDTH_MAX}) ?
    `SOMI_WIDTH_MAX : abs_width[`SOMI_CNT_W-1:0];
  assign tick = busy && (pre == PRE_LAST);

  // Notice sequencer; a start overrides a completion in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre <= {`SOMI_PRE_W{1'b0}};
      remaining <= {`SOMI_CNT_W{1'b0}};
      busy <= 1'b0;
      pending <= 1'b0;
      follow <= 1'b0;
      in_position_out <= 1'b0;
    end else if (positioning_start) begin
      in_position_out <= 1'b0;
      follow <= 1'b0;
      pending <= 1'b0;
      pre <= {`SOMI_PRE_W{1'b0}};
      remaining <= mag;
      busy <= mode_latched;
    end else if (positioning_done) begin
      pre <= {`SOMI_PRE_W{1'b0}};
      if (mode_latched) begin
        if (busy) begin
          pending <= 1'b1;
        end else begin
          in_position_out <= 1'b1;
        end
      end else if (mode_follow) begin
        follow <= 1'b1;
        busy <= 1'b0;
        in_position_out <= pos_err_ok;
      end else begin
        in_position_out <= 1'b1;
        remaining <= mag;
        busy <= 1'b1;
        follow <= 1'b0;
      end
    end else begin
      if (busy) begin
        pre <= tick ? {`SOMI_PRE_W{1'b0}} : pre + 1'b1;
      end
      if (tick) begin
        remaining <= remaining - 1'b1;
        if (remaining <= {{(`SOMI_CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          if (pending) begin
            in_position_out <= 1'b1;
            pending <= 1'b0;
          end else if (mode_pulse) begin
            in_position_out <= 1'b0;
          end
        end
      end
      if (follow) begin
        in_position_out <= pos_err_ok;
      end
    end
  end

endmodule
`default_nettype wire

//--- logic/somi_top.v
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "somi_defines.vh"

module somi_top (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [`SOMI_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [`SOMI_DATA_W-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`SOMI_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [`SOMI_DATA_W-1:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Raw comparator states from the driver core
  input wire thermal_under_out,
  input wire thermal_over_out,
  input wire torque_over_out,
  input wire torque_under_out,
  input wire velerr_over_out,
  input wire velerr_under_out,
  input wire vel_over_out,
  input wire vel_under_out,
  input wire warning_out,
  input wire zone_a_out,
  input wire zone_b_out,
  input wire zone_c_out,
  // Position error within in-position band
  input wire pos_err_ok,
  // Feedback phase Z sources
  input wire index_pulse_in,
  input wire index_msb_in,
  // Positioning events from the motion core, same clock
  input wire positioning_start,
  input wire positioning_done,
  // Outputs
  output wire in_position_out,
  output reg phase_z_out,
  output reg irq
);

  reg [31:0] inpos_width_setting;
  reg index_format_setting;
  reg [`SOMI_EVT_W-1:0] status;
  reg [`SOMI_EVT_W-1:0] enable;
  reg inpos_prev;
  reg warn_prev;
  reg [`SOMI_ADDR_W-1:0] wr_addr;
  reg [`SOMI_DATA_W-1:0] wr_data;
  reg [3:0] wr_strb;
  wire [`SOMI_SYN_W-1:0] raw_in;
  wire [`SOMI_SYN_W-1:0] syn;
  wire [`SOMI_MON_W-1:0] monitor;
  wire mode_latched;
  wire mode_follow;
  wire mode_pulse;
  wire timing;
  wire do_write;
  wire [`SOMI_SEL_W-1:0] wr_sel;
  wire [`SOMI_SEL_W-1:0] rd_sel;
  wire [`SOMI_EVT_W-1:0] events;
  wire [`SOMI_EVT_W-1:0] clear_mask;
  wire [31:0] next_width;
  wire [31:0] next_config;
  wire [31:0] next_enable;
  reg [`SOMI_DATA_W-1:0] rd_word;

  // One-hot register select for an aligned word address
  function [`SOMI_SEL_W-1:0] reg_select;
    input [`SOMI_ADDR_W-1:0] addr;
    begin
      reg_select = {`SOMI_SEL_W{1'b0}};
      if (addr[1:0] == 2'b00) begin
        case (addr)
          `SOMI_OFF_MONITOR: reg_select[`SOMI_SEL_MONITOR] = 1'b1;
          `SOMI_OFF_WIDTH: reg_select[`SOMI_SEL_WIDTH] = 1'b1;
          `SOMI_OFF_CONFIG: reg_select[`SOMI_SEL_CONFIG] = 1'b1;
          `SOMI_OFF_STATUS: reg_select[`SOMI_SEL_STATUS] = 1'b1;
          `SOMI_OFF_CLEAR: reg_select[`SOMI_SEL_CLEAR] = 1'b1;
          `SOMI_OFF_ENABLE: reg_select[`SOMI_SEL_ENABLE] = 1'b1;
          `SOMI_OFF_OUTPUT: reg_select[`SOMI_SEL_OUTPUT] = 1'b1;
          default: reg_select = {`SOMI_SEL_W{1'b0}};
        endcase
      end
    end
  endfunction

  // Byte-lane merge of a write into an old value
  function [31:0] merge_bytes;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] strb;
    integer b;
    begin
      merge_bytes = old_value;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_bytes[8*b +: 8] = new_value[8*b +: 8];
        end
      end
    end
  endfunction

  // Gather pin-level inputs for synchronisation
  assign raw_in[`SOMI_MON_THERMAL_UNDER] = thermal_under_out;
  assign raw_in[`SOMI_MON_THERMAL_OVER] = thermal_over_out;
  assign raw_in[`SOMI_MON_TORQUE_OVER] = torque_over_out;
  assign raw_in[`SOMI_MON_TORQUE_UNDER] = torque_under_out;
  assign raw_in[`SOMI_MON_VELERR_OVER] = velerr_over_out;
  assign raw_in[`SOMI_MON_VELERR_UNDER] = velerr_under_out;
  assign raw_in[`SOMI_MON_VEL_OVER] = vel_over_out;
  assign raw_in[`SOMI_MON_VEL_UNDER] = vel_under_out;
  assign raw_in[`SOMI_MON_WARNING] = warning_out;
  assign raw_in[`SOMI_MON_ZONE_A] = zone_a_out;
  assign raw_in[`SOMI_MON_ZONE_B] = zone_b_out;
  assign raw_in[`SOMI_MON_ZONE_C] = zone_c_out;
  assign raw_in[`SOMI_SYN_POS_ERR] = pos_err_ok;
  assign raw_in[`SOMI_SYN_INDEX] = index_pulse_in;
  assign raw_in[`SOMI_SYN_MSB] = index_msb_in;

  somi_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // Monitors are the raw states, no stability delay or polarity applied
  assign monitor[`SOMI_MON_THERMAL_UNDER] =
    syn[`SOMI_MON_THERMAL_UNDER];
  assign monitor[`SOMI_MON_THERMAL_OVER] =
    syn[`SOMI_MON_THERMAL_OVER];
  assign monitor[`SOMI_MON_TORQUE_OVER] = syn[`SOMI_MON_TORQUE_OVER];
  assign monitor[`SOMI_MON_TORQUE_UNDER] =
    syn[`SOMI_MON_TORQUE_UNDER];
  assign monitor[`SOMI_MON_VELERR_OVER] = syn[`SOMI_MON_VELERR_OVER];
  assign monitor[`SOMI_MON_VELERR_UNDER] =
    syn[`SOMI_MON_VELERR_UNDER];
  assign monitor[`SOMI_MON_VEL_OVER] = syn[`SOMI_MON_VEL_OVER];
  assign monitor[`SOMI_MON_VEL_UNDER] = syn[`SOMI_MON_VEL_UNDER];
  assign monitor[`SOMI_MON_WARNING] = syn[`SOMI_MON_WARNING];
  assign monitor[`SOMI_MON_ZONE_A] = syn[`SOMI_MON_ZONE_A];
  assign monitor[`SOMI_MON_ZONE_B] = syn[`SOMI_MON_ZONE_B];
  assign monitor[`SOMI_MON_ZONE_C] = syn[`SOMI_MON_ZONE_C];

  somi_inpos u_inpos (
    .aclk(aclk),
    .aresetn(aresetn),
    .inpos_width_setting(inpos_width_setting),
    .positioning_start(positioning_start),
    .positioning_done(positioning_done),
    .pos_err_ok(syn[`SOMI_SYN_POS_ERR]),
    .in_position_out(in_position_out),
    .mode_latched(mode_latched),
    .mode_follow(mode_follow),
    .mode_pulse(mode_pulse),
    .timing(timing)
  );

  // Phase Z format selection, registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_z_out <= 1'b0;
    end else begin
      phase_z_out <= index_format_setting ?
        syn[`SOMI_SYN_MSB] : syn[`SOMI_SYN_INDEX];
    end
  end

  // Write path: address and data taken in either order
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sel = reg_select(wr_addr);
  assign rd_sel = reg_select(s_axi_araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SOMI_RESP_OKAY;
      wr_addr <= {`SOMI_ADDR_W{1'b0}};
      wr_data <= {`SOMI_DATA_W{1'b0}};
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == {`SOMI_SEL_W{1'b0}}) ?
          `SOMI_RESP_DECERR : `SOMI_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers with byte strobes
  assign next_width = merge_bytes(inpos_width_setting, wr_data, wr_strb);
  assign next_config = merge_bytes({31'h00000000, index_format_setting},
    wr_data, wr_strb);
  assign next_enable = merge_bytes({29'h00000000, enable}, wr_data, wr_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      inpos_width_setting <= `SOMI_RST_WIDTH;
      index_format_setting <= `SOMI_RST_CONFIG;
      enable <= `SOMI_RST_ENABLE;
    end else if (do_write) begin
      if (wr_sel[`SOMI_SEL_WIDTH]) begin
        inpos_width_setting <= next_width;
      end
      if (wr_sel[`SOMI_SEL_CONFIG]) begin
        index_format_setting <= next_config[`SOMI_CFG_INDEX_FMT];
      end
      if (wr_sel[`SOMI_SEL_ENABLE]) begin
        enable <= next_enable[`SOMI_EVT_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  assign events[`SOMI_EVT_INPOS_RISE] = in_position_out && !inpos_prev;
  assign events[`SOMI_EVT_INPOS_FALL] = !in_position_out && inpos_prev;
  assign events[`SOMI_EVT_WARN_RISE] =
    monitor[`SOMI_MON_WARNING] && !warn_prev;
  assign clear_mask = (do_write && wr_sel[`SOMI_SEL_CLEAR]) ?
    (wr_data[`SOMI_EVT_W-1:0] & {`SOMI_EVT_W{wr_strb[0]}}) :
    {`SOMI_EVT_W{1'b0}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= {`SOMI_EVT_W{1'b0}};
      inpos_prev <= 1'b0;
      warn_prev <= 1'b0;
      irq <= 1'b0;
    end else begin
      inpos_prev <= in_position_out;
      warn_prev <= monitor[`SOMI_MON_WARNING];
      status <= (status & ~clear_mask) | events;
      irq <= |(((status & ~clear_mask) | events) & enable);
    end
  end

  // Read word multiplexer; reads change no state
  always @* begin
    rd_word = {`SOMI_DATA_W{1'b0}};
    case (1'b1)
      rd_sel[`SOMI_SEL_MONITOR]: rd_word[`SOMI_MON_W-1:0] = monitor;
      rd_sel[`SOMI_SEL_WIDTH]: rd_word = inpos_width_setting;
      rd_sel[`SOMI_SEL_CONFIG]: rd_word[`SOMI_CFG_INDEX_FMT] =
        index_format_setting;
      rd_sel[`SOMI_SEL_STATUS]: rd_word[`SOMI_EVT_W-1:0] = status;
      rd_sel[`SOMI_SEL_ENABLE]: rd_word[`SOMI_EVT_W-1:0] = enable;
      rd_sel[`SOMI_SEL_OUTPUT]: begin
        rd_word[`SOMI_OUT_INPOS] = in_position_out;
        rd_word[`SOMI_OUT_MODE_LATCH] = mode_latched;
        rd_word[`SOMI_OUT_MODE_FOLLOW] = mode_follow;
        rd_word[`SOMI_OUT_MODE_PULSE] = mode_pulse;
        rd_word[`SOMI_OUT_TIMING] = timing;
      end
      default: rd_word = {`SOMI_DATA_W{1'b0}};
    endcase
  end

  // Read path: one answer per address, held until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= {`SOMI_DATA_W{1'b0}};
      s_axi_rresp <= `SOMI_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_sel == {`SOMI_SEL_W{1'b0}}) ?
          `SOMI_RESP_DECERR : `SOMI_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- verification/somi_host.sv
`timescale 1ns/10ps
`default_nettype none
module somi_host (
  input wire logic aclk,
  output logic [7:0] awaddr = 8'h00,
  output logic awvalid = 1'b0,
  output logic [31:0] wdata = 32'h0,
  output logic [3:0] wstrb = 4'h0,
  output logic wvalid = 1'b0,
  output logic bready = 1'b0,
  output logic [7:0] araddr = 8'h00,
  output logic arvalid = 1'b0,
  output logic rready = 1'b0,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid
);
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/somi_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "somi_defines.vh"
module somi_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`SOMI_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic positioning_start,
  input wire logic in_position_out,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers and holding
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  chk_b_blocks: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready early");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  chk_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  chk_decerr_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `SOMI_RESP_DECERR |-> s_axi_rdata == 32'h0)
    else $error("decerr data not zero");
  // In-position opens on a start; irq, in-position and bvalid low out of reset
  chk_start_opens: assert property (positioning_start |=>
    !in_position_out) else $error("inpos held after start");
  chk_reset_quiet: assert property ($rose(aresetn) |-> !irq &&
    !in_position_out && !s_axi_bvalid) else $error("reset outputs");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(in_position_out));
  cover property ($rose(irq));
endmodule
bind somi_top somi_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .positioning_start(positioning_start),
  .in_position_out(in_position_out), .irq(irq));
`default_nettype wire

//--- verification/test_servo_output_monitor_inpos.sv
`timescale 1ns/10ps
`default_nettype none
`include "somi_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module test_servo_output_monitor_inpos;
  localparam int U = 4000;
  logic aclk = 0, aresetn = 0, pos_ok = 0, idx_p = 0, idx_m = 0;
  logic p_start = 0, p_done = 0;
  logic [11:0] mon_in = 12'h000;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  wire arready, rvalid, rready, inpos, phz, irq;
  int n_errors = 0, num_checks = 0, cnt;
  // Model of the register file
  logic [31:0] m_width = `SOMI_RST_WIDTH;
  logic [11:0] m_mon = 12'h000;
  logic [2:0] m_en = 3'h0, m_stat = 3'h0;
  logic m_cfg = 1'b0, m_out = 1'b0;
  logic [11:0] vq[$];
  logic [31:0] wv[4] = '{32'hFFFFFFFF, 32'h0, 32'h1, 32'hFFFE7960};
  always #12.5 aclk = ~aclk;
  somi_host host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .rready(rready),
    .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid));
  somi_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .thermal_under_out(mon_in[0]),
    .thermal_over_out(mon_in[1]), .torque_over_out(mon_in[2]),
    .torque_under_out(mon_in[3]), .velerr_over_out(mon_in[4]),
    .velerr_under_out(mon_in[5]), .vel_over_out(mon_in[6]),
    .vel_under_out(mon_in[7]), .warning_out(mon_in[8]),
    .zone_a_out(mon_in[9]), .zone_b_out(mon_in[10]),
    .zone_c_out(mon_in[11]), .pos_err_ok(pos_ok),
    .index_pulse_in(idx_p), .index_msb_in(idx_m),
    .positioning_start(p_start), .positioning_done(p_done),
    .in_position_out(inpos), .phase_z_out(phz), .irq(irq));
  // Expected read data from the model
  function automatic logic [31:0] model_rd(logic [7:0] a);
    case (a)
      `SOMI_OFF_MONITOR: return {20'h0, m_mon};
      `SOMI_OFF_WIDTH: return m_width;
      `SOMI_OFF_CONFIG: return {31'h0, m_cfg};
      `SOMI_OFF_STATUS: return {29'h0, m_stat};
      `SOMI_OFF_ENABLE: return {29'h0, m_en};
      `SOMI_OFF_OUTPUT: return {28'h0, $signed(m_width) > 0,
        m_width == 32'h0, $signed(m_width) < 0, m_out};
      default: return 32'h0;
    endcase
  endfunction
  task automatic rd_chk(input logic [7:0] a, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    `CHK(r, er)
    `CHK(d, model_rd(a))
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    logic [1:0] er;
    er = (a > `SOMI_OFF_OUTPUT || a[1:0] != 2'b00) ?
      `SOMI_RESP_DECERR : `SOMI_RESP_OKAY;
    host_u.wr(a, d, r);
    `CHK(r, er)
    if (a == `SOMI_OFF_WIDTH) m_width = d;
    if (a == `SOMI_OFF_CONFIG) m_cfg = d[0];
    if (a == `SOMI_OFF_ENABLE) m_en = d[2:0];
    if (a == `SOMI_OFF_CLEAR) m_stat = m_stat & ~d[2:0];
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic pulse(input bit is_start);
    @(posedge aclk);
    if (is_start) p_start <= 1'b1;
    else p_done <= 1'b1;
    @(posedge aclk);
    p_start <= 1'b0;
    p_done <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(30000 * 25);
    n_errors++;
    results;
  end
  initial begin
    void'($urandom(32'hc7ee831b));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and map, unmapped and unaligned places
    for (int i = 0; i < 8; i++)
      rd_chk(8'(i * 4), i == 7 ? `SOMI_RESP_DECERR : `SOMI_RESP_OKAY);
    rd_chk(8'h02, `SOMI_RESP_DECERR);
    // Monitors: walking one, then random patterns, each read twice
    for (int i = 0; i < 12; i++) vq.push_back(12'h001 << i);
    repeat (8) vq.push_back(12'($urandom));
    while (vq.size() > 0) begin
      @(posedge aclk);
      mon_in <= vq[0];
      m_mon = vq.pop_front();
      cyc(4);
      rd_chk(`SOMI_OFF_MONITOR, `SOMI_RESP_OKAY);
      rd_chk(`SOMI_OFF_MONITOR, `SOMI_RESP_OKAY);
    end
    wr_chk(`SOMI_OFF_MONITOR, 32'hFFFFFFFF);
    rd_chk(`SOMI_OFF_MONITOR, `SOMI_RESP_OKAY);
    // Unmapped write answers DECERR and leaves the width alone
    wr_chk(8'h1C, 32'hFFFFFFFF);
    rd_chk(`SOMI_OFF_WIDTH, `SOMI_RESP_OKAY);
    // Index format selects the phase Z source
    for (int c = 0; c < 4; c++) begin
      wr_chk(`SOMI_OFF_CONFIG, 32'(c / 2));
      @(posedge aclk);
      idx_p <= c[0];
      idx_m <= ~c[0];
      cyc(5);
      `CHK(phz, (c / 2 == 0) ? c[0] : ~c[0])
    end
    // Mode from the sign of the width
    for (int k = 0; k < 4; k++) begin
      wr_chk(`SOMI_OFF_WIDTH, wv[k]);
      rd_chk(`SOMI_OFF_OUTPUT, `SOMI_RESP_OKAY);
    end
    // Pulse mode: one pulse of width ticks, events and interrupt
    wr_chk(`SOMI_OFF_CLEAR, 32'h7);
    wr_chk(`SOMI_OFF_WIDTH, 32'h1);
    pulse(1'b0);
    cnt = 0;
    // Sample once after every edge, from the done edge onward
    repeat (U + 20) begin
      #1;
      if (inpos === 1'b1) cnt++;
      @(posedge aclk);
    end
    `CHK(cnt, U)
    m_stat = 3'h3;
    rd_chk(`SOMI_OFF_STATUS, `SOMI_RESP_OKAY);
    `CHK(irq, 1'b0)
    wr_chk(`SOMI_OFF_ENABLE, 32'h1);
    cyc(3);
    `CHK(irq, 1'b1)
    wr_chk(`SOMI_OFF_CLEAR, 32'h1);
    cyc(3);
    `CHK(irq, 1'b0)
    rd_chk(`SOMI_OFF_STATUS, `SOMI_RESP_OKAY);
    // Latched mode: early done waits out the width, then holds
    wr_chk(`SOMI_OFF_WIDTH, 32'hFFFFFFFF);
    pulse(1'b1);
    cyc(10);
    pulse(1'b0);
    cyc(U - 150);
    `CHK(inpos, 1'b0)
    cyc(300);
    `CHK(inpos, 1'b1)
    m_out = 1'b1;
    rd_chk(`SOMI_OFF_OUTPUT, `SOMI_RESP_OKAY);
    pulse(1'b1);
    cyc(1);
    `CHK(inpos, 1'b0)
    m_out = 1'b0;
    // Follow mode: output tracks the error state only after done
    wr_chk(`SOMI_OFF_WIDTH, 32'h0);
    pulse(1'b1);
    pos_ok <= 1'b1;
    cyc(6);
    `CHK(inpos, 1'b0)
    pulse(1'b0);
    cyc(6);
    `CHK(inpos, 1'b1)
    @(posedge aclk);
    pos_ok <= 1'b0;
    cyc(6);
    `CHK(inpos, 1'b0)
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    cyc(3);
    @(posedge aclk);
    aresetn <= 1'b1;
    m_width = `SOMI_RST_WIDTH;
    m_cfg = 1'b0;
    m_en = 3'h0;
    m_stat = 3'h0;
    rd_chk(`SOMI_OFF_WIDTH, `SOMI_RESP_OKAY);
    rd_chk(`SOMI_OFF_ENABLE, `SOMI_RESP_OKAY);
    results;
  end
endmodule
`default_nettype wire
